// ---- verilog/vfd_host_port.sv ----
// Host port of a character display controller: parallel 8/4-bit and
// strobed serial access to the instruction and data registers.
// Assumes a host bus on slow pins, sampled by a 40 MHz core_clk.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "vfd_regs.svh"

module vfd_host_port import vfd_pkg::*; (
  // Clock, reset, enable
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       clkEn,
  // Parallel host pins
  input  wire logic       pinE,
  input  wire logic       pinRs,
  input  wire logic       pinRw,
  input  wire logic [7:0] pinDbIn,
  output logic      [7:0] pinDbOut,
  output logic            pinDbOe,
  // Serial host pins
  input  wire logic       pinStb,
  input  wire logic       pinSck,
  input  wire logic       pinSioIn,
  output logic            pinSioOut,
  output logic            pinSioOe,
  // Local register port
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // Controller side
  output logic            accStb,
  output logic            accRs,
  output logic      [7:0] accData,
  output logic            busyOut,
  output logic            wideBus,
  output logic            twoLines,
  output logic      [1:0] brightness,
  output logic      [2:0] displayCtl,
  output logic            textLine,
  output logic      [5:0] textColumn,
  output logic            glyphSel
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  vfd_state_t s;                             // Registered state
  vfd_state_t next_s;                        // Next state
  vfd_pins_t  p;                             // Synchronised pins
  logic [7:0] textRam [`VFD_TEXT_DEPTH];     // Display text memory
  logic [4:0] glyphRam [`VFD_GLYPH_DEPTH];   // Glyph pattern memory
  logic [7:0] ramByte;                       // Memory at current address
  logic       eFall;                         // Enable falling edge
  logic       sckRise;                       // Serial clock rise
  logic       sckFall;                       // Serial clock fall
  logic       stbFall;                       // Strobe falling edge
  logic       doWr;                          // Write access completes
  logic       wrRs;                          // Its register select
  logic [7:0] wrByte;                        // Its byte
  logic       doRd;                          // Read access completes
  logic       rdRs;                          // Its register select
  logic [7:0] rb;                            // Byte offered to a read
  logic [7:0] sb;                            // Serial byte being handled
  logic       syncOk;                        // Start byte field matches

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Mask and compare a command byte
  function automatic logic cmdMatch(input logic [7:0] b, input logic [7:0] m,
                                    input logic [7:0] c);
    cmdMatch = (b & m) == c;
  endfunction

  // Byte returned by a read: status word or memory contents
  function automatic logic [7:0] readByte(input logic rs, input logic bsy,
                                          input logic [6:0] a,
                                          input logic [7:0] mem);
    readByte = rs ? mem : {bsy, a};
  endfunction

  // Address step after a data access; glyph space wraps at 64
  function automatic logic [6:0] nextAddr(input logic [6:0] a, input logic g);
    nextAddr = g ? {1'b0, a[5:0] + 6'h01} : a + 7'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  vfd_sync u_sync (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .asyncPins ({pinE, pinRs, pinRw, pinDbIn, pinStb, pinSck, pinSioIn}),
    .syncPins  (p)
  );

  // Memory read at the address counter
  assign ramByte = s.glyphSel ? {3'h0, glyphRam[s.addr[5:0]]} : textRam[s.addr];

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_s    = s;
    eFall     = s.ePrev & ~p.e;
    sckRise   = ~s.sckPrev & p.sck;
    sckFall   = s.sckPrev & ~p.sck;
    stbFall   = s.stbPrev & ~p.stb;
    doWr      = 1'b0;
    wrRs      = 1'b0;
    wrByte    = 8'h00;
    doRd      = 1'b0;
    rdRs      = 1'b0;
    sb        = 8'h00;
    syncOk    = 1'b0;
    rb        = readByte(p.rs, s.busy, s.addr, ramByte);
    next_s.ePrev    = p.e;
    next_s.sckPrev  = p.sck;
    next_s.stbPrev  = p.stb;
    next_s.accStb   = 1'b0;
    next_s.regRdata = 8'h00;
    // Execution timer runs down
    if (s.busyCnt != 8'h00) begin
      next_s.busyCnt = s.busyCnt - 8'h01;
    end

    // Parallel path: act on the enable fall
    if (!s.serMode) begin
      if (eFall) begin
        if (p.rw) begin
          // Read ends at a byte or at the second nibble
          doRd = s.wide | s.nibPhase;
          rdRs = p.rs;
          if (!s.wide) begin
            next_s.nibPhase = ~s.nibPhase;
          end
        end else if (s.wide) begin
          doWr   = 1'b1;
          wrRs   = p.rs;
          wrByte = p.db;
        end else if (!s.nibPhase) begin
          // First nibble is the high half; lower lines unused
          next_s.hiNib    = p.db[7:4];
          next_s.nibPhase = 1'b1;
        end else begin
          doWr   = 1'b1;
          wrRs   = p.rs;
          wrByte = {s.hiNib, p.db[7:4]};
          next_s.nibPhase = 1'b0;
        end
      end
      // Drive the bus while enable is high on a read
      next_s.dbOe  = p.e & p.rw;
      next_s.dbOut = s.wide ? rb : (s.nibPhase ? {rb[3:0], 4'h0}
                                               : {rb[7:4], 4'h0});
    end else begin
      next_s.dbOe = 1'b0;
    end

    // Serial path
    if (s.serMode) begin
      if (p.stb) begin
        next_s.ser = SER_IDLE;
      end else if (stbFall) begin
        // Fresh frame; any partial byte is dropped
        next_s.ser    = SER_START;
        next_s.bitCnt = 3'h0;
      end else begin
        case (s.ser)
          // Start byte: shift in on rising edges
          SER_START: begin
            if (sckRise) begin
              sb            = {s.shift[6:0], p.si};
              next_s.shift  = sb;
              next_s.bitCnt = s.bitCnt + 3'h1;
              if (s.bitCnt == `VFD_BIT_LAST) begin
                syncOk       = sb[7:3] == s.syncVal;
                next_s.serRw = sb[2];
                next_s.serRs = sb[1];
                if (!syncOk) begin
                  next_s.ser      = SER_SKIP;
                  next_s.frameBad = 1'b1;
                end else begin
                  next_s.ser = sb[2] ? SER_READ : SER_DATA;
                end
              end
            end
          end
          // Data bytes of a write frame
          SER_DATA: begin
            if (sckRise) begin
              sb            = {s.shift[6:0], p.si};
              next_s.shift  = sb;
              next_s.bitCnt = s.bitCnt + 3'h1;
              if (s.bitCnt == `VFD_BIT_LAST) begin
                doWr   = 1'b1;
                wrRs   = s.serRs;
                wrByte = sb;
              end
            end
          end
          // Read frame: one bit out per falling edge, MSB first
          SER_READ: begin
            if (sckFall) begin
              sb = (s.bitCnt == 3'h0) ?
                   readByte(s.serRs, s.busy, s.addr, ramByte) : s.shift;
              next_s.sioOut = sb[7];
              next_s.shift  = {sb[6:0], 1'b0};
              next_s.bitCnt = s.bitCnt + 3'h1;
              if (s.bitCnt == `VFD_BIT_LAST) begin
                doRd = 1'b1;
                rdRs = s.serRs;
              end
            end
          end
          // Idle or rejected: wait for the next strobe fall
          default: begin
            next_s.ser = s.ser;
          end
        endcase
      end
    end else begin
      next_s.ser = SER_IDLE;
    end
    next_s.sioOe = s.serMode & ~p.stb & (next_s.ser == SER_READ);

    // Completed write: hand over and decode commands
    if (doWr) begin
      next_s.accStb  = 1'b1;
      next_s.accRs   = wrRs;
      next_s.accData = wrByte;
      next_s.busyCnt = 8'(`VFD_EXEC_CYC);
      if (wrRs) begin
        next_s.addr = nextAddr(s.addr, s.glyphSel);
      end else if (cmdMatch(wrByte, `VFD_TA_MASK, `VFD_TA_CODE)) begin
        next_s.addr     = wrByte[6:0];
        next_s.glyphSel = 1'b0;
      end else if (cmdMatch(wrByte, `VFD_GA_MASK, `VFD_GA_CODE)) begin
        next_s.addr     = {1'b0, wrByte[5:0]};
        next_s.glyphSel = 1'b1;
      end else if (cmdMatch(wrByte, `VFD_FS_MASK, `VFD_FS_CODE)) begin
        next_s.wide     = wrByte[`VFD_FS_IF];
        next_s.twoLines = wrByte[`VFD_FS_N];
        next_s.bright   = wrByte[1:0];
        next_s.nibPhase = 1'b0;
      end else if (cmdMatch(wrByte, `VFD_DC_MASK, `VFD_DC_CODE)) begin
        next_s.dispCtl = wrByte[2:0];
      end else if (cmdMatch(wrByte, `VFD_HOME_MASK, `VFD_HOME_CODE) ||
                   wrByte == `VFD_CLR_CODE) begin
        next_s.addr     = 7'h00;
        next_s.glyphSel = 1'b0;
      end
    end
    // Data reads step the address counter
    if (doRd && rdRs) begin
      next_s.addr = nextAddr(s.addr, s.glyphSel);
    end
    next_s.busy = next_s.busyCnt != 8'h00;

    // Local register port; a new fault wins over a clear
    if (regWr) begin
      if (regAddr == `VFD_REG_CTRL) begin
        next_s.serMode = regWdata[`VFD_CTRL_SERIAL];
        if (regWdata[`VFD_CTRL_SERIAL] != s.serMode) begin
          next_s.nibPhase = 1'b0;
          next_s.ser      = SER_IDLE;
        end
      end else if (regAddr == `VFD_REG_SYNC) begin
        next_s.syncVal = regWdata[4:0];
      end else if (regAddr == `VFD_REG_STAT) begin
        if (regWdata[`VFD_STAT_BAD] && !(next_s.ser == SER_SKIP && s.ser != SER_SKIP)) begin
          next_s.frameBad = 1'b0;
        end
      end
    end
    if (regRd) begin
      if (regAddr == `VFD_REG_CTRL) begin
        next_s.regRdata = {7'h00, s.serMode};
      end else if (regAddr == `VFD_REG_SYNC) begin
        next_s.regRdata = {3'h0, s.syncVal};
      end else if (regAddr == `VFD_REG_STAT) begin
        next_s.regRdata = {s.busy, s.wide, s.twoLines, s.frameBad,
                           s.nibPhase, s.dispCtl};
      end else begin
        next_s.regRdata = {s.glyphSel, s.addr};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; frozen while the enable is low

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s         <= '0;
      s.wide    <= `VFD_WIDE_RST;
      s.syncVal <= `VFD_SYNC_RST;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  // Memories: no reset, contents are host-loaded
  always_ff @(posedge core_clk) begin
    if (clkEn && doWr && wrRs) begin
      if (s.glyphSel) begin
        glyphRam[s.addr[5:0]] <= wrByte[4:0];
      end else begin
        textRam[s.addr] <= wrByte;
      end
    end
  end

  // Outputs straight from the state register
  assign pinDbOut   = s.dbOut;
  assign pinDbOe    = s.dbOe;
  assign pinSioOut  = s.sioOut;
  assign pinSioOe   = s.sioOe;
  assign regRdata   = s.regRdata;
  assign accStb     = s.accStb;
  assign accRs      = s.accRs;
  assign accData    = s.accData;
  assign busyOut    = s.busy;
  assign wideBus    = s.wide;
  assign twoLines   = s.twoLines;
  assign brightness = s.bright;
  assign displayCtl = s.dispCtl;
  assign textLine   = s.addr[6];
  assign textColumn = s.addr[5:0];
  assign glyphSel   = s.glyphSel;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence seqNibHi;
    clkEn && !s.serMode && !s.wide && eFall && !p.rw && !s.nibPhase;
  endsequence
  sequence seqNibLo;
    clkEn && !s.serMode && !s.wide && eFall && !p.rw && s.nibPhase;
  endsequence

  a_wide_write: assert property (clkEn && !s.serMode && s.wide && eFall && !p.rw
    |=> accStb && accData == $past(p.db)) else $error("byte write lost");
  a_nib_first: assert property (seqNibHi |=> !accStb && s.nibPhase)
    else $error("first nibble completed an access");
  a_nib_order: assert property (seqNibHi ##[1:100] seqNibLo
    |=> accStb && accData[3:0] == $past(p.db[7:4])) else $error("nibble order");
  a_ser_quiet: assert property (clkEn && s.serMode && p.stb
    |=> s.ser == SER_IDLE && !pinSioOe) else $error("serial active, strobe high");
  a_ser_restart: assert property (clkEn && s.serMode && stbFall
    |=> s.ser == SER_START && s.bitCnt == 3'h0) else $error("no frame restart");
  a_sync_reject: assert property (clkEn && !p.stb && s.ser == SER_START && sckRise
    && s.bitCnt == `VFD_BIT_LAST && !syncOk |=> s.ser == SER_SKIP && s.frameBad)
    else $error("bad sync accepted");
  a_ser_write: assert property (clkEn && !p.stb && s.ser == SER_DATA && sckRise
    && s.bitCnt == `VFD_BIT_LAST |=> accStb && accRs == $past(s.serRs))
    else $error("serial byte lost");
  a_so_fall: assert property (!$stable(s.sioOut) |-> $past(sckFall))
    else $error("serial out moved off a falling edge");
  a_busy_set: assert property (accStb |-> busyOut ##1 busyOut)
    else $error("busy not raised");
  a_width_bit: assert property (clkEn && doWr && !wrRs
    && cmdMatch(wrByte, `VFD_FS_MASK, `VFD_FS_CODE) |=> wideBus == $past(wrByte[4]))
    else $error("width bit ignored");
  a_line_map: assert property (clkEn && doWr && !wrRs && wrByte == 8'hC0
    |=> textLine && textColumn == 6'h00) else $error("lower line map");

endmodule // vfd_host_port

// ---- verilog/vfd_regs.svh ----
// Constants for the display host port: register map, field positions,
// reset values, command codes and timing counts.
// Assumes a 40 MHz core clock; included by the port and the testbench.
`ifndef VFD_REGS_SVH
`define VFD_REGS_SVH

// Local register map (word index on regAddr)
`define VFD_REG_CTRL      2'h0
`define VFD_REG_SYNC      2'h1
`define VFD_REG_STAT      2'h2
`define VFD_REG_ADDR      2'h3

// Field positions
`define VFD_CTRL_SERIAL   0
`define VFD_STAT_BAD      4
`define VFD_FS_IF         4
`define VFD_FS_N          3

// Reset values
`define VFD_SYNC_RST      5'h1F
`define VFD_WIDE_RST      1'b1

// Timing: execution time after a write, and derived cycle count
`define VFD_EXEC_NS       1000
`define VFD_CLK_NS        25
`define VFD_EXEC_CYC      ((`VFD_EXEC_NS + `VFD_CLK_NS - 1) / `VFD_CLK_NS)

// Command decode: mask and pattern pairs
`define VFD_CLR_CODE      8'h01
`define VFD_HOME_MASK     8'hFE
`define VFD_HOME_CODE     8'h02
`define VFD_DC_MASK       8'hF8
`define VFD_DC_CODE       8'h08
`define VFD_FS_MASK       8'hE0
`define VFD_FS_CODE       8'h20
`define VFD_GA_MASK       8'hC0
`define VFD_GA_CODE       8'h40
`define VFD_TA_MASK       8'h80
`define VFD_TA_CODE       8'h80

// Memory geometry
`define VFD_LINE2_ADDR    7'h40
`define VFD_GLYPH_DEPTH   64
`define VFD_TEXT_DEPTH    128
`define VFD_BIT_LAST      3'h7

`endif

// ---- verilog/vfd_pkg.sv ----
// Types shared by the display host port and its pin synchroniser.
// Assumes vfd_regs.svh supplies every numeric constant.
package vfd_pkg;

  // Host pins as seen by the core after synchronising
  typedef struct packed {
    logic       e;
    logic       rs;
    logic       rw;
    logic [7:0] db;
    logic       stb;
    logic       sck;
    logic       si;
  } vfd_pins_t;

  // Two synchroniser stages
  typedef struct packed {
    vfd_pins_t stage1;
    vfd_pins_t stage2;
  } vfd_sync_t;

  // Serial frame states
  typedef enum logic [2:0] {
    SER_IDLE,
    SER_START,
    SER_DATA,
    SER_READ,
    SER_SKIP
  } vfd_ser_t;

  // Whole state of the host port
  typedef struct packed {
    logic       serMode;
    logic [4:0] syncVal;
    logic       wide;
    logic       twoLines;
    logic [1:0] bright;
    logic [2:0] dispCtl;
    logic [6:0] addr;
    logic       glyphSel;
    logic [7:0] busyCnt;
    logic       busy;
    logic       nibPhase;
    logic [3:0] hiNib;
    logic       ePrev;
    logic       sckPrev;
    logic       stbPrev;
    vfd_ser_t   ser;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    logic       serRs;
    logic       serRw;
    logic       frameBad;
    logic [7:0] dbOut;
    logic       dbOe;
    logic       sioOut;
    logic       sioOe;
    logic       accStb;
    logic       accRs;
    logic [7:0] accData;
    logic [7:0] regRdata;
  } vfd_state_t;

endpackage

// ---- verilog/vfd_sync.sv ----
// Two-stage synchroniser for every host pin of the display port.
// Assumes pins are asynchronous to core_clk; stage1 feeds stage2 only.
`timescale 1ns/1ps

module vfd_sync import vfd_pkg::*; (
  // Clock and control
  input  wire logic      core_clk,
  input  wire logic      sys_rst,
  input  wire logic      clkEn,
  // Pins in, synchronised pins out
  input  wire vfd_pins_t asyncPins,
  output vfd_pins_t      syncPins
);

  vfd_sync_t s;       // Both stages
  vfd_sync_t next_s;  // Next value

  // Shift pins one stage per edge
  always_comb begin
    next_s.stage1 = asyncPins;
    next_s.stage2 = s.stage1;
  end

  // Register stages; frozen while the enable is low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  assign syncPins = s.stage2;

endmodule // vfd_sync

// ---- testbench/vfd_host_model.sv ----
// Host processor model: drives the parallel and serial pins of the port.
// Assumes core_clk paces every pin edge; released lines float high (pull-ups).
`timescale 1ns/1ps

module vfd_host_model (
  // Clock
  input  wire logic       core_clk,
  // Parallel pins
  output logic            pinE,
  output logic            pinRs,
  output logic            pinRw,
  output logic      [7:0] pinDbIn,
  input  wire logic [7:0] pinDbOut,
  input  wire logic       pinDbOe,
  // Serial pins
  output logic            pinStb,
  output logic            pinSck,
  output logic            pinSioIn,
  input  wire logic       pinSioOut,
  input  wire logic       pinSioOe
);
  logic [7:0] dbDrv;  // Host data, all ones once released
  logic       sioDrv; // Host serial bit, one once released

  // Wire levels: the device wins while it drives, host data or pull-ups otherwise
  assign pinDbIn  = pinDbOe ? pinDbOut : dbDrv;
  assign pinSioIn = pinSioOe ? pinSioOut : sioDrv;

  // Idle pins; the serial clock stands high outside frames
  initial begin
    {pinE, pinRs, pinRw} = 3'h0;
    {pinStb, pinSck, sioDrv} = 3'h7;
    dbDrv = 8'hFF;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One enable pulse; lines held well past the fall since sync adds delay
  task automatic par_xfer(input logic rs, input logic rw, input logic [7:0] v,
                          output logic [7:0] rd);
    @(posedge core_clk);
    pinRs <= rs;
    pinRw <= rw;
    dbDrv <= rw ? 8'hFF : v;
    cyc(4);
    pinE <= 1'b1;
    cyc(7);
    #1 rd = pinDbIn;
    @(posedge core_clk);
    pinE <= 1'b0;
    cyc(6);
    dbDrv <= 8'hFF;
  endtask

  // Strobed frame of nbits; a short count aborts it mid-byte
  task automatic ser_frame(input logic rs, input logic rw, input logic [4:0] sy,
                           input logic [7:0] v, input int nbits, output logic [7:0] rd);
    logic [15:0] w;
    w  = {sy, rw, rs, 1'b0, v};
    rd = 8'h00;
    @(posedge core_clk);
    pinStb <= 1'b0;
    cyc(4);
    for (int i = 0; i < nbits; i++) begin
      pinSck <= 1'b0;
      sioDrv <= (rw && i > 7) ? 1'b1 : w[15-i];
      cyc(4);
      pinSck <= 1'b1;
      cyc(3);
      #1 if (i > 7) rd[15-i] = pinSioIn;
      @(posedge core_clk);
    end
    cyc(3);
    pinStb <= 1'b1;
    sioDrv <= 1'b1;
    cyc(8);
  endtask
endmodule // vfd_host_model

// ---- testbench/vfd_module_host_interface_tb.sv ----
// Bench for the display host port: host model on the pins, tasks on the
// local register port. Assumes the package and header compile first.
`timescale 1ns/1ps
`include "vfd_regs.svh"

module vfd_module_host_interface_tb;
  logic       core_clk = 1'b0;
  logic       sys_rst  = 1'b1;
  logic       clkEn    = 1'b1; // Always running
  logic [1:0] regAddr  = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWr    = 1'b0;
  logic       regRd    = 1'b0;
  logic       pinE, pinRs, pinRw, pinStb, pinSck, pinSioIn, pinSioOut, pinSioOe, pinDbOe;
  logic [7:0] pinDbIn, pinDbOut, regRdata, accData, rd, d;
  logic       accStb, accRs, busyOut, wideBus, twoLines, textLine, glyphSel;
  logic [1:0] brightness;
  logic [2:0] displayCtl;
  logic [5:0] textColumn;
  int         err_total = 0;
  int         tests_run = 0;
  int         accCnt    = 0;
  int         n0        = 0;
  int         seed      = 98690;

  vfd_host_port i_vfd_host_port (
    .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .pinE(pinE), .pinRs(pinRs), .pinRw(pinRw), .pinDbIn(pinDbIn),
    .pinDbOut(pinDbOut), .pinDbOe(pinDbOe), .pinStb(pinStb), .pinSck(pinSck),
    .pinSioIn(pinSioIn), .pinSioOut(pinSioOut), .pinSioOe(pinSioOe),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .accStb(accStb), .accRs(accRs), .accData(accData),
    .busyOut(busyOut), .wideBus(wideBus), .twoLines(twoLines), .brightness(brightness),
    .displayCtl(displayCtl), .textLine(textLine), .textColumn(textColumn),
    .glyphSel(glyphSel));

  vfd_host_model i_vfd_host_model (
    .core_clk(core_clk), .pinE(pinE), .pinRs(pinRs), .pinRw(pinRw),
    .pinDbIn(pinDbIn), .pinDbOut(pinDbOut), .pinDbOe(pinDbOe), .pinStb(pinStb),
    .pinSck(pinSck), .pinSioIn(pinSioIn), .pinSioOut(pinSioOut), .pinSioOe(pinSioOe));

  always #12.5 core_clk = ~core_clk;

  // Completed accesses, counted so a lone nibble shows as no access
  always @(posedge core_clk) if (accStb === 1'b1) accCnt <= accCnt + 1;

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic acc_chk(input int c0, input logic rs, input logic [7:0] exp);
    chk(8'h01, 8'(accCnt - c0));
    chk({7'h0, rs}, {7'h0, accRs});
    chk(exp, accData);
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1 v = regRdata;
  endtask

  // Bounded poll of busy before any new byte
  task automatic wait_idle;
    int n;
    repeat (4) @(posedge core_clk);
    for (n = 0; n < 200 && busyOut !== 1'b0; n++) @(posedge core_clk);
    if (n == 200) chk(8'h00, 8'h01);
  endtask

  task automatic pcmd(input logic rs, input logic [7:0] c);
    int c0;
    c0 = accCnt;
    wait_idle();
    i_vfd_host_model.par_xfer(rs, 1'b0, c, rd);
    repeat (4) @(posedge core_clk);
    acc_chk(c0, rs, c);
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, far beyond the expected run of under 0.15 millisecond
  initial begin
    #1000000;
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    reg_rd(`VFD_REG_SYNC, rd);
    chk(8'h1F, rd);
    repeat (4000) @(posedge core_clk);
    pcmd(1'b0, 8'h38);
    chk(8'h03, {4'h0, brightness, wideBus, twoLines});
    i_vfd_host_model.par_xfer(1'b0, 1'b1, 8'h00, rd);
    chk(8'h80, rd & 8'h80);
    pcmd(1'b0, 8'h0C);
    chk(8'h04, {5'h0, displayCtl});
    pcmd(1'b0, 8'h40);
    reg_rd(`VFD_REG_ADDR, rd);
    chk(8'h81, {rd[7:1], glyphSel});
    d = 8'($random(seed));
    pcmd(1'b1, {3'h0, d[4:0]});
    pcmd(1'b0, 8'h01);
    chk(8'h00, {glyphSel, textLine, textColumn});
    pcmd(1'b0, 8'hC0);
    chk(8'h40, {1'b0, textLine, textColumn});
    pcmd(1'b1, d);
    chk(8'h41, {1'b0, textLine, textColumn});
    pcmd(1'b0, 8'h28);
    chk(8'h00, {7'h0, wideBus});
    // Nibble pairs, no busy poll between halves, junk on the lower lines
    for (int k = 0; k < 4; k++) begin
      d  = 8'($random(seed));
      n0 = accCnt;
      wait_idle();
      i_vfd_host_model.par_xfer(1'b1, 1'b0, {d[7:4], ~d[3:0]}, rd);
      repeat (4) @(posedge core_clk);
      chk(8'h00, 8'(accCnt - n0));
      i_vfd_host_model.par_xfer(1'b1, 1'b0, {d[3:0], d[7:4]}, rd);
      repeat (4) @(posedge core_clk);
      acc_chk(n0, 1'b1, d);
    end
    wait_idle();
    i_vfd_host_model.par_xfer(1'b0, 1'b1, 8'h00, rd);
    chk(8'h40, rd);
    i_vfd_host_model.par_xfer(1'b0, 1'b1, 8'h00, rd);
    chk(8'h50, rd);
    reg_wr(`VFD_REG_CTRL, 8'h01);
    n0 = accCnt;
    i_vfd_host_model.ser_frame(1'b1, 1'b0, 5'h0A, 8'h55, 16, rd);
    repeat (4) @(posedge core_clk);
    chk(8'h00, 8'(accCnt - n0));
    reg_rd(`VFD_REG_STAT, rd);
    chk(8'h10, rd & 8'h10);
    reg_wr(`VFD_REG_STAT, 8'h10);
    reg_rd(`VFD_REG_STAT, rd);
    chk(8'h24, rd);
    d = 8'($random(seed));
    reg_wr(`VFD_REG_SYNC, {3'h0, d[4:0]});
    n0 = accCnt;
    i_vfd_host_model.ser_frame(1'b1, 1'b0, d[4:0], 8'h00, 3, rd);
    i_vfd_host_model.ser_frame(1'b1, 1'b0, d[4:0], ~d, 16, rd);
    repeat (4) @(posedge core_clk);
    acc_chk(n0, 1'b1, ~d);
    wait_idle();
    n0 = accCnt;
    i_vfd_host_model.ser_frame(1'b0, 1'b0, d[4:0], 8'h85, 16, rd);
    repeat (4) @(posedge core_clk);
    acc_chk(n0, 1'b0, 8'h85);
    wait_idle();
    i_vfd_host_model.ser_frame(1'b0, 1'b1, d[4:0], 8'h00, 16, rd);
    chk(8'h05, rd);
    wrap_up();
  end
endmodule // vfd_module_host_interface_tb
